// *** hdl/ccd_readout_pkg.sv ***
// constants and types for the ccd frame readout sequencer
package ccd_readout_pkg;
  // frame geometry in rows
  localparam int unsigned top_dark_rows = 2;
  localparam int unsigned active_rows = 1208;
  localparam int unsigned bottom_dark_rows = 4;
  localparam int unsigned buffer_rows = 4;
  localparam int unsigned frame_rows = top_dark_rows + active_rows + bottom_dark_rows;
  // line geometry in pixels
  localparam int unsigned empty_pix = 4;
  localparam int unsigned dark_pix = 16;
  localparam int unsigned photo_pix_single = 1608;
  localparam int unsigned photo_pix_dual = 804;
  localparam int unsigned buffer_pix = 4;
  localparam int unsigned line_pix_single = 1644;
  localparam int unsigned line_pix_dual = 824;
  // pixel timing: clock cycles per half phase, rounded up to stay under the rate cap
  localparam int unsigned clock_mhz = 125;
  localparam int unsigned pix_rate_fast_mhz = 40;
  localparam int unsigned pix_rate_slow_mhz = 20;
  localparam int unsigned pix_cycles_fast = (clock_mhz + pix_rate_fast_mhz - 1) / pix_rate_fast_mhz;
  localparam int unsigned pix_cycles_slow = (clock_mhz + pix_rate_slow_mhz - 1) / pix_rate_slow_mhz;
  // vertical pulse width and hold delay
  localparam int unsigned v_pulse_ns = 1000;
  localparam int unsigned v_pulse_cycles = (v_pulse_ns * clock_mhz + 999) / 1000;
  localparam int unsigned hold_delay_default = 125;
  // field widths
  localparam int unsigned cnt_w = 12;
  localparam int unsigned row_w = 11;
  localparam int unsigned hold_w = 12;
  typedef enum logic [2:0]
  {
    st_idle = 3'b000,
    st_vpulse = 3'b001,
    st_hold = 3'b010,
    st_hshift = 3'b011,
    st_done = 3'b100
  } seq_state_t;
endpackage

// *** hdl/ccd_frame_readout_sequencer.sv ***
// timing generator that reads one ccd frame through its clock phase pins
//
// Overview of operation
// - receiver reverses right samples in line buffer, appends after left.
// - dark reference uses only central 14 of 16 dark columns, no rows.
// - during vertical shift hold horizontal one high, horizontal two low.
// - restart horizontal clocking only after programmable hold delay.
// - no shutter, vertical or dump pulses while shifting image pixels.
// - two 824-cell halves; barrier phases set same or opposite direction.
// - single mode phase mapping: right barrier one takes phase two timing.
// - single mode issues 1644 horizontal cycles per line.
// - dual mode phase mapping: all phase-one inputs take phase one timing.
// - dual mode issues 824 horizontal cycles per line.
// - right barrier phases generated separately, inverted, edges aligned.
// - reset clock pulses after each pixel is sampled.
// - slow 20 mhz pixel rate for full binned range, else 40 mhz.
`timescale 1ns/1ps
module ccd_frame_readout_sequencer
  import ccd_readout_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic frame_start,
  input wire logic dual_mode,
  input wire logic slow_rate,
  input wire logic dump_request,
  input wire logic [hold_w-1:0] hold_cycles,
  output logic vertical_phase_one,
  output logic vertical_phase_two,
  output logic left_storage_phase_one,
  output logic left_storage_phase_two,
  output logic left_barrier_phase_one,
  output logic left_barrier_phase_two,
  output logic right_storage_phase_one,
  output logic right_storage_phase_two,
  output logic right_barrier_phase_one,
  output logic right_barrier_phase_two,
  output logic reset_clock,
  output logic line_dump_gate,
  output logic sample_strobe,
  output logic image_valid,
  output logic dark_ref_valid,
  output logic frame_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  seq_state_t state_q;
  logic dual_q;
  logic slow_q;
  logic dump_q;
  logic [row_w-1:0] row_q;
  logic [cnt_w-1:0] pix_q;
  logic [hold_w-1:0] wait_q;
  logic [2:0] div_q;
  logic h_phase_q;
  logic [2:0] half_cycles;
  logic [cnt_w-1:0] line_len;
  logic pix_end;

  // position decoders used for image and dark flags
  function automatic logic is_image_row(input logic [row_w-1:0] r);
    return (r >= row_w'(top_dark_rows + buffer_rows)) &&
           (r < row_w'(top_dark_rows + active_rows - buffer_rows));
  endfunction

  function automatic logic is_image_pix(input logic [cnt_w-1:0] p, input logic dual);
    logic [cnt_w-1:0] first;
    logic [cnt_w-1:0] last;
    first = cnt_w'(empty_pix + dark_pix + buffer_pix);
    last = dual ? cnt_w'(line_pix_dual) : cnt_w'(line_pix_single - dark_pix - buffer_pix);
    return (p >= first) && (p < last);
  endfunction

  function automatic logic is_dark_ref_pix(input logic [cnt_w-1:0] p, input logic dual);
    logic lead;
    logic trail;
    lead = (p > cnt_w'(empty_pix)) && (p < cnt_w'(empty_pix + dark_pix - 1));
    trail = !dual && (p > cnt_w'(line_pix_single - dark_pix)) &&
            (p < cnt_w'(line_pix_single - 1));
    return lead || trail;
  endfunction

  assign half_cycles = slow_q ? 3'(pix_cycles_slow) : 3'(pix_cycles_fast);
  assign line_len = dual_q ? cnt_w'(line_pix_dual) : cnt_w'(line_pix_single);
  assign pix_end = (div_q == half_cycles - 3'h1) && h_phase_q;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state machine
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= st_idle;
      row_q <= '0;
      pix_q <= '0;
      wait_q <= '0;
    end
    else
    begin
      unique case (state_q)
        st_idle:
        begin
          if (frame_start)
          begin
            state_q <= st_vpulse;
            row_q <= '0;
            wait_q <= '0;
          end
        end
        st_vpulse:
        begin
          // one vertical step per line
          wait_q <= wait_q + hold_w'(1);
          if (wait_q == hold_w'(v_pulse_cycles - 1))
          begin
            state_q <= st_hold;
            wait_q <= '0;
          end
        end
        st_hold:
        begin
          wait_q <= wait_q + hold_w'(1);
          if (wait_q >= hold_cycles)
          begin
            state_q <= dump_q ? st_done : st_hshift;
            pix_q <= '0;
          end
        end
        st_hshift:
        begin
          if (pix_end)
          begin
            pix_q <= pix_q + cnt_w'(1);
            if (pix_q == line_len - cnt_w'(1))
              state_q <= st_done;
          end
        end
        st_done:
        begin
          wait_q <= '0;
          row_q <= row_q + row_w'(1);
          state_q <= (row_q == row_w'(frame_rows - 1)) ? st_idle : st_vpulse;
        end
        default:
          state_q <= st_idle;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode latch at frame start, dump request latched per line
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      dual_q <= 1'b0;
      slow_q <= 1'b0;
      dump_q <= 1'b0;
    end
    else
    begin
      if (state_q == st_idle && frame_start)
      begin
        dual_q <= dual_mode;
        slow_q <= slow_rate;
      end
      // taken once per line so gate and skip decision always agree
      if (state_q == st_idle || state_q == st_done)
        dump_q <= dump_request;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pixel clock divider
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      div_q <= '0;
      h_phase_q <= 1'b0;
    end
    else if (state_q != st_hshift)
    begin
      div_q <= '0;
      h_phase_q <= 1'b0;
    end
    else if (div_q == half_cycles - 3'h1)
    begin
      div_q <= '0;
      h_phase_q <= !h_phase_q;
    end
    else
      div_q <= div_q + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      vertical_phase_one <= 1'b0;
      vertical_phase_two <= 1'b0;
      line_dump_gate <= 1'b0;
      left_storage_phase_one <= 1'b1;
      left_barrier_phase_one <= 1'b1;
      right_storage_phase_one <= 1'b1;
      left_storage_phase_two <= 1'b0;
      left_barrier_phase_two <= 1'b0;
      right_storage_phase_two <= 1'b0;
      right_barrier_phase_one <= 1'b0;
      right_barrier_phase_two <= 1'b1;
      reset_clock <= 1'b0;
    end
    else
    begin
      // vertical and dump only outside horizontal shifting
      vertical_phase_one <= (state_q == st_vpulse);
      vertical_phase_two <= (state_q == st_vpulse);
      line_dump_gate <= dump_q && (state_q == st_vpulse || state_q == st_hold);
      // phase one high while halted, toggles while shifting
      left_storage_phase_one <= !h_phase_q;
      left_barrier_phase_one <= !h_phase_q;
      right_storage_phase_one <= !h_phase_q;
      left_storage_phase_two <= h_phase_q;
      left_barrier_phase_two <= h_phase_q;
      right_storage_phase_two <= h_phase_q;
      // right barriers swap between modes
      right_barrier_phase_one <= dual_q ? !h_phase_q : h_phase_q;
      right_barrier_phase_two <= dual_q ? h_phase_q : !h_phase_q;
      // reset pulse in first half phase of each pixel, after prior sample
      reset_clock <= (state_q == st_hshift) && !h_phase_q &&
                     (div_q == 3'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample strobe and pixel classification for the adc side
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sample_strobe <= 1'b0;
      image_valid <= 1'b0;
      dark_ref_valid <= 1'b0;
      frame_busy <= 1'b0;
    end
    else
    begin
      sample_strobe <= (state_q == st_hshift) && pix_end;
      image_valid <= (state_q == st_hshift) && pix_end && is_image_row(row_q) &&
                     is_image_pix(pix_q, dual_q);
      dark_ref_valid <= (state_q == st_hshift) && pix_end && is_image_row(row_q) &&
                        is_dark_ref_pix(pix_q, dual_q);
      frame_busy <= (state_q != st_idle);
    end
  end

endmodule

// *** testbench/ccd_seq_properties.sv ***
// concurrent checks on the readout sequencer ports
`timescale 1ns/1ps
module ccd_seq_properties
  import ccd_readout_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic frame_start,
  input wire logic dual_mode,
  input wire logic [hold_w-1:0] hold_cycles,
  input wire logic vertical_phase_one,
  input wire logic vertical_phase_two,
  input wire logic left_storage_phase_one,
  input wire logic left_storage_phase_two,
  input wire logic left_barrier_phase_one,
  input wire logic left_barrier_phase_two,
  input wire logic right_storage_phase_one,
  input wire logic right_storage_phase_two,
  input wire logic right_barrier_phase_one,
  input wire logic right_barrier_phase_two,
  input wire logic reset_clock,
  input wire logic line_dump_gate,
  input wire logic sample_strobe,
  input wire logic image_valid,
  input wire logic dark_ref_valid,
  input wire logic frame_busy
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  logic mode_q;
  logic [7:0] vcnt_q;
  logic [12:0] hcnt_q;
  // mode as taken at frame start, vertical pulse length
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      mode_q <= 1'b0;
    else if (frame_start && !frame_busy)
      mode_q <= dual_mode;
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      vcnt_q <= 8'h00;
    else
      vcnt_q <= vertical_phase_one ? vcnt_q + 8'h01 : 8'h00;
  // cycles since the vertical pulse fell, saturating
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      hcnt_q <= 13'h0000;
    else if (vertical_phase_one)
      hcnt_q <= 13'h0000;
    else if (hcnt_q != 13'h1fff)
      hcnt_q <= hcnt_q + 13'h0001;
  a_start_answer: assert property (
    frame_start && !frame_busy |-> ##2 frame_busy && vertical_phase_one)
    else $error("frame start not answered");
  a_hold_length: assert property (
    $fell(left_storage_phase_one) |-> hcnt_q > {1'b0, hold_cycles})
    else $error("hold delay too short");
  a_vert_pair: assert property (
    vertical_phase_one == vertical_phase_two)
    else $error("vertical phases differ");
  a_vert_width: assert property (
    $fell(vertical_phase_one) |-> vcnt_q == v_pulse_cycles)
    else $error("vertical pulse length wrong");
  a_h_parked: assert property (
    vertical_phase_one |-> left_storage_phase_one && !left_storage_phase_two)
    else $error("horizontal not parked");
  a_hold_delay: assert property (
    $fell(vertical_phase_one) |-> (left_storage_phase_one && !left_storage_phase_two) [*2])
    else $error("horizontal restarted early");
  a_barrier_map: assert property (
    sample_strobe |-> right_storage_phase_one == left_storage_phase_one
      && left_barrier_phase_one == left_storage_phase_one
      && left_barrier_phase_two == left_storage_phase_two
      && right_storage_phase_two == left_storage_phase_two
      && left_storage_phase_two != left_storage_phase_one
      && right_barrier_phase_one == (mode_q ? left_storage_phase_one : left_storage_phase_two)
      && right_barrier_phase_two != right_barrier_phase_one)
    else $error("barrier mapping wrong");
  a_image_quiet: assert property (
    image_valid |-> sample_strobe && !vertical_phase_one && !line_dump_gate)
    else $error("noise during image");
  a_dark_ref: assert property (
    dark_ref_valid |-> sample_strobe && !image_valid)
    else $error("dark reference misplaced");
  a_dump_parked: assert property (
    line_dump_gate |-> left_storage_phase_one && !left_storage_phase_two)
    else $error("shift during dump");
  a_reset_pulse: assert property (
    reset_clock |-> !sample_strobe ##1 !reset_clock)
    else $error("reset pulse wrong");
endmodule
bind ccd_frame_readout_sequencer ccd_seq_properties ccd_seq_properties_inst (
  .clock, .rstn, .frame_start, .dual_mode, .hold_cycles, .vertical_phase_one,
  .vertical_phase_two, .left_storage_phase_one, .left_storage_phase_two,
  .left_barrier_phase_one, .left_barrier_phase_two, .right_storage_phase_one,
  .right_storage_phase_two,
  .right_barrier_phase_one, .right_barrier_phase_two, .reset_clock, .line_dump_gate,
  .sample_strobe, .image_valid, .dark_ref_valid, .frame_busy);

// *** testbench/ccd_sensor_model.sv ***
// behavioural sensor that follows its phase pins
`timescale 1ns/1ps
module ccd_sensor_model
  import ccd_readout_pkg::*;
(
  input wire logic vertical_phase_one,
  input wire logic right_barrier_phase_one,
  input wire logic line_dump_gate,
  input wire logic reset_clock,
  output logic [1:0] left_video_output,
  output logic [1:0] right_video_output
);
  logic dual_q = 1'b0;
  logic dump_q = 1'b1;
  int idx = 0;
  initial left_video_output = 2'd3;
  initial right_video_output = 2'd0;
  // row enters the register unless dumped; barriers set direction
  always @(negedge vertical_phase_one)
  begin
    dump_q = line_dump_gate;
    dual_q = right_barrier_phase_one;
    idx = -1;
  end
  // reset gate clears the node, the next cell's charge arrives
  always @(posedge reset_clock)
  begin
    idx = idx + 1;
    if (dump_q || idx < empty_pix)
      left_video_output = 2'd0;
    else if (idx < empty_pix + dark_pix || idx >= (dual_q ? 824 : 1628))
      left_video_output = 2'd1;
    else
      left_video_output = 2'd2;
    // reversed right half leaves the right output only in dual mode
    right_video_output = dual_q ? left_video_output : 2'd0;
  end
endmodule

// *** testbench/ccd_frame_readout_sequencer_test.sv ***
// self-checking bench for the readout sequencer
`timescale 1ns/1ps
module ccd_frame_readout_sequencer_test;
  import ccd_readout_pkg::*;
  logic clock = 0, rstn = 0, frame_start = 0, dual_mode = 0, slow_rate = 0, dump_request = 0;
  logic [hold_w-1:0] hold_cycles = 12'h002;
  logic vertical_phase_one, right_barrier_phase_one, reset_clock, line_dump_gate;
  logic sample_strobe, image_valid, dark_ref_valid, v1_d, seen;
  logic [1:0] left_video_output, right_video_output;
  logic [11:0] exp_q[$];
  logic [11:0] ns, ni, nd, np, ng;
  logic [31:0] seed = 32'he636;
  int errors = 0, n_compared = 0, rises = 0;
  ccd_frame_readout_sequencer ccd_frame_readout_sequencer_inst (.clock, .rstn, .frame_start,
    .dual_mode, .slow_rate, .dump_request, .hold_cycles, .vertical_phase_one,
    .vertical_phase_two(), .left_storage_phase_one(), .left_storage_phase_two(),
    .left_barrier_phase_one(), .left_barrier_phase_two(), .right_storage_phase_one(),
    .right_storage_phase_two(), .right_barrier_phase_one, .right_barrier_phase_two(),
    .reset_clock, .line_dump_gate, .sample_strobe, .image_valid, .dark_ref_valid,
    .frame_busy());
  ccd_sensor_model ccd_sensor_model_inst (.vertical_phase_one, .right_barrier_phase_one,
    .line_dump_gate, .reset_clock, .left_video_output, .right_video_output);
  initial forever #4 clock = ~clock;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic print_verdict();
    if (errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [11:0] got);
    logic [11:0] e;
    e = exp_q.pop_front();
    n_compared++;
    if (got !== e)
    begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, e);
    end
  endtask
  //////////////////////////////
  // per-line tallies, compared at the next vertical transfer
  always @(posedge clock)
  begin
    if (rstn && vertical_phase_one && !v1_d && seen && exp_q.size() > 4)
    begin
      check(ns);
      check(ni);
      check(nd);
      check(np);
      check(ng);
    end
    if (rstn && vertical_phase_one && !v1_d)
      rises++;
    seen = rstn && (seen || (vertical_phase_one && !v1_d));
    if (!rstn || (vertical_phase_one && !v1_d))
      {ns, ni, nd, np, ng} = '0;
    if (sample_strobe)
    begin
      ns = ns + 12'h001;
      ni = ni + 12'(image_valid);
      nd = nd + 12'(dark_ref_valid);
      // rebuilt line: left photo pixels plus the appended right half
      np = np + 12'(left_video_output == 2'd2) + 12'(right_video_output == 2'd2);
    end
    // dump gate seen by the vertical transfer, whole pulse counted
    if (line_dump_gate && vertical_phase_one)
      ng = ng + 12'h001;
    v1_d = vertical_phase_one;
  end
  // start a frame, then a mode flip that must be ignored, then rows lines of it, then reset
  // the first ndump rows are dumped, the rest read in full
  task automatic run_frame(input logic dm, input logic sr, input int ndump, input int rows);
    int k;
    int ln;
    int base;
    logic im;
    seed = xs(seed);
    base = rises;
    hold_cycles <= 12'(2 + seed[2:0]);
    {dual_mode, slow_rate, dump_request, frame_start} <= {dm, sr, ndump > 0, 1'b1};
    for (k = 0; k < rows; k++)
    begin
      ln = k < ndump ? 0 : (dm ? line_pix_dual : line_pix_single);
      im = k >= top_dark_rows + buffer_rows && ln != 0;
      exp_q.push_back(12'(ln));
      exp_q.push_back(im ? (dm ? 12'd800 : 12'd1600) : 12'h000);
      exp_q.push_back(im ? (dm ? 12'd14 : 12'd28) : 12'h000);
      exp_q.push_back(ln == 0 ? 12'h000 : 12'(photo_pix_single));
      exp_q.push_back(ln == 0 ? 12'(v_pulse_cycles) : 12'h000);
    end
    repeat (3) @(posedge clock);
    dual_mode <= ~dm;
    for (k = 0; k < 60000 && rises < base + rows + 1; k++)
    begin
      @(posedge clock);
      dump_request <= (rises - base) < ndump;
    end
    if (rises < base + rows + 1)
      errors++;
    {frame_start, rstn} <= 2'b00;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
  endtask
  initial
  begin
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    run_frame(1'b0, 1'b0, 5, 7);
    run_frame(1'b1, 1'b1, 5, 7);
    run_frame(1'b1, 1'b0, 3, 3);
    print_verdict();
  end
endmodule
